// ---- rtl/srap_dev.sv ----
// Purpose: register port end, serial slave with byte register access
// Assumes: link sclk at most a quarter of the core clock rate
// Notes:   all link inputs pass a two-stage synchroniser
`timescale 1ns/10ps
`include "srap_cfg.svh"
module srap_dev (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Serial link
  srap_if.dev link,
  // Link status sent at each start
  input wire srap_pkg::srap_stat_t status_i,
  // Register file access
  output logic reg_rd_o,
  output logic reg_wr_o,
  output srap_pkg::srap_addr_t reg_addr_o,
  output srap_pkg::srap_byte_t reg_wdata_o,
  input wire srap_pkg::srap_byte_t reg_rdata_i,
  input wire logic reg_addr_bad_i,
  // Fault event
  output logic fault_o
);
  import srap_pkg::*;

  logic [1:0] sclk_sync_q;
  logic [1:0] sel_sync_q;
  logic [1:0] mosi_sync_q;
  logic sclk_old_q;
  logic sel_old_q;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_rise;
  logic sel_fall;
  logic sel_on;
  logic byte_done;
  logic end_err;
  srap_byte_t rx_byte;
  logic [2:0] bit_q;
  srap_byte_t rx_q;
  srap_byte_t tx_q;
  srap_byte_t stl_q;
  srap_byte_t rdq_q;
  logic [1:0] byte_idx_q;
  logic miso_q;
  logic fault_q;
  logic fault_pulse_q;
  srap_dev_st_t st_q;
  srap_addr_t addr_q;
  logic got_q;
  logic check_q;
  logic reg_rd_q;
  logic reg_wr_q;
  srap_addr_t reg_addr_q;
  srap_byte_t reg_wdata_q;

  // Two-stage synchronisers and edge history
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      sclk_sync_q <= 2'h0;
      sel_sync_q <= 2'h0;
      mosi_sync_q <= 2'h0;
      sclk_old_q <= 1'b0;
      sel_old_q <= 1'b0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[0], link.sclk};
      sel_sync_q <= {sel_sync_q[0], link.sel};
      mosi_sync_q <= {mosi_sync_q[0], link.mosi};
      sclk_old_q <= sclk_sync_q[1];
      sel_old_q <= sel_sync_q[1];
    end
  end

  // Edge detection on synchronised levels
  assign sel_on = sel_sync_q[1];
  assign sel_rise = sel_on & ~sel_old_q;
  assign sel_fall = ~sel_on & sel_old_q;
  assign sclk_rise = sel_on & ~sel_rise & sclk_sync_q[1] & ~sclk_old_q;
  assign sclk_fall = sel_on & ~sel_rise & ~sclk_sync_q[1] & sclk_old_q;
  assign rx_byte = {rx_q[6:0], mosi_sync_q[1]};
  assign byte_done = sclk_fall & (bit_q == 3'h7);

  // Errors found when select is released
  assign end_err = ~fault_q & ((bit_q != 3'h0)
                   | ((st_q == DEV_WDATA) & ~got_q));

  // Bit counter and receive shifter, sampled on falling clock
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !sel_on || sel_rise) begin
      bit_q <= 3'h0;
      rx_q <= 8'h00;
    end else if (sclk_fall) begin
      bit_q <= bit_q + 3'h1;
      rx_q <= rx_byte;
    end
  end

  // Byte position within the select window, saturates at two
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || sel_rise) begin
      byte_idx_q <= 2'h0;
    end else if (byte_done && byte_idx_q != 2'h2) begin
      byte_idx_q <= byte_idx_q + 2'h1;
    end
  end

  // Status low byte held so both halves match
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      stl_q <= 8'h00;
    end else if (sel_rise) begin
      stl_q <= status_i[7:0];
    end
  end

  // Transmit shifter, new bit out on rising clock
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      tx_q <= 8'h00;
      miso_q <= 1'b0;
    end else if (sel_rise) begin
      tx_q <= status_i[15:8];
      miso_q <= 1'b0;
    end else if (!sel_on) begin
      miso_q <= fault_q;
    end else if (fault_q) begin
      miso_q <= 1'b1;
    end else if (byte_done) begin
      // Status once, then read data two bytes behind command
      tx_q <= (byte_idx_q == 2'h0) ? stl_q : rdq_q;
    end else if (sclk_rise) begin
      miso_q <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // Read data captured in the cycle of the read strobe
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || sel_rise) begin
      rdq_q <= 8'h00;
    end else if (reg_rd_q) begin
      rdq_q <= reg_rdata_i;
    end else if (byte_done) begin
      rdq_q <= 8'h00;
    end
  end

  // Fault tracking, address faults end with select
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      fault_q <= 1'b0;
      fault_pulse_q <= 1'b0;
    end else begin
      fault_pulse_q <= 1'b0;
      if (sel_rise) begin
        fault_q <= 1'b0;
      end else if (sel_fall) begin
        fault_q <= end_err;
        fault_pulse_q <= end_err;
      end else if (sel_on && !fault_q && check_q && reg_addr_bad_i) begin
        fault_q <= 1'b1;
        fault_pulse_q <= 1'b1;
      end
    end
  end

  // Command and data decoding per received byte
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      st_q <= DEV_CMD;
      addr_q <= 7'h00;
      got_q <= 1'b0;
      check_q <= 1'b0;
      reg_rd_q <= 1'b0;
      reg_wr_q <= 1'b0;
      reg_addr_q <= 7'h00;
      reg_wdata_q <= 8'h00;
    end else begin
      reg_rd_q <= 1'b0;
      reg_wr_q <= 1'b0;
      check_q <= 1'b0;
      if (!sel_on || sel_rise) begin
        st_q <= DEV_CMD;
        got_q <= 1'b0;
      end else if (fault_q) begin
        st_q <= DEV_FAULT;
      end else if (byte_done) begin
        unique case (st_q)
          DEV_CMD: begin
            reg_addr_q <= rx_byte[6:0];
            check_q <= 1'b1;
            if (srap_is_rd(rx_byte)) begin
              // Filler address is not forwarded
              reg_rd_q <= (rx_byte[6:0] != `SRAP_FILLER_ADDR);
            end else begin
              st_q <= DEV_WDATA;
              addr_q <= rx_byte[6:0];
            end
          end
          DEV_WDATA: begin
            reg_addr_q <= addr_q;
            reg_wdata_q <= rx_byte;
            reg_wr_q <= 1'b1;
            check_q <= 1'b1;
            addr_q <= addr_q + 7'h01;
            got_q <= 1'b1;
          end
          DEV_FAULT: begin
            // Bytes ignored until select drops
            st_q <= DEV_FAULT;
          end
        endcase
      end
    end
  end

  // Outputs straight from flip-flops
  assign link.miso = miso_q;
  assign reg_rd_o = reg_rd_q;
  assign reg_wr_o = reg_wr_q;
  assign reg_addr_o = reg_addr_q;
  assign reg_wdata_o = reg_wdata_q;
  assign fault_o = fault_pulse_q;

endmodule

// ---- rtl/srap_cfg.svh ----
// Purpose: shared constants of the serial register access port
// Assumes: 25 MHz core clock on both ends
// Notes:   times in ns, cycle counts derived and rounded up
`ifndef SRAP_CFG_SVH
`define SRAP_CFG_SVH

// Command byte layout
`define SRAP_ACC_BIT 7
`define SRAP_ACC_WR 1'b0
`define SRAP_ACC_RD 1'b1
`define SRAP_FILLER_ADDR 7'h3F
`define SRAP_FILL_BYTES 2'h2

// Link timing, ns
`define SRAP_CLK_NS 40
`define SRAP_HALF_NS 160
`define SRAP_SETUP_NS 25
`define SRAP_HOLD_NS 260
`define SRAP_GAP_NS 50

// Least times rounded up to whole clock cycles
`define SRAP_CYC(ns) (((ns) + `SRAP_CLK_NS - 1) / `SRAP_CLK_NS)
`define SRAP_HALF_CYC 4'(`SRAP_CYC(`SRAP_HALF_NS))
`define SRAP_SETUP_CYC 4'(`SRAP_CYC(`SRAP_SETUP_NS))
`define SRAP_HOLD_CYC 4'(`SRAP_CYC(`SRAP_HOLD_NS))
`define SRAP_GAP_CYC 4'(`SRAP_CYC(`SRAP_GAP_NS))

`endif

// ---- rtl/srap_pkg.sv ----
// Purpose: types and command helpers of the serial register access port
// Assumes: srap_cfg.svh holds all numbers
// Notes:   shared by both ends
`include "srap_cfg.svh"
package srap_pkg;

  typedef logic [7:0] srap_byte_t;
  typedef logic [6:0] srap_addr_t;
  typedef logic [15:0] srap_stat_t;

  // Device decode states
  typedef enum logic [1:0] {DEV_CMD, DEV_WDATA, DEV_FAULT} srap_dev_st_t;

  // Host link sequencer states
  typedef enum logic [2:0] {
    HST_IDLE, HST_SETUP, HST_HIGH, HST_LOW, HST_HOLD, HST_GAP
  } srap_host_st_t;

  // True when a command byte asks for a read
  function automatic logic srap_is_rd(input srap_byte_t b);
    return b[`SRAP_ACC_BIT] == `SRAP_ACC_RD;
  endfunction

  // Build a command byte from access type and address
  function automatic srap_byte_t srap_cmd(input logic rd, input srap_addr_t a);
    return {(rd ? `SRAP_ACC_RD : `SRAP_ACC_WR), a};
  endfunction

endpackage

// ---- rtl/srap_if.sv ----
// Purpose: serial link between drive controller and register port
// Assumes: select active high, clock idles low
// Notes:   all four wires single direction
`timescale 1ns/10ps
interface srap_if;
  logic sclk;
  logic sel;
  logic mosi;
  logic miso;

  // Register port end
  modport dev (input sclk, input sel, input mosi, output miso);
  // Drive controller end
  modport host (output sclk, output sel, output mosi, input miso);
endinterface

// ---- rtl/srap_host.sv ----
// Purpose: drive controller end, serial master moving bytes
// Assumes: user feeds command and data bytes of one transaction
// Notes:   link clock made here by counting core clocks
`timescale 1ns/10ps
`include "srap_cfg.svh"
module srap_host (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Serial link
  srap_if.host link,
  // Bytes to send
  input wire logic tx_valid_i,
  input wire srap_pkg::srap_byte_t tx_data_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  input wire logic abort_i,
  // Bytes received
  output logic rx_valid_o,
  output srap_pkg::srap_byte_t rx_data_o,
  output logic busy_o
);
  import srap_pkg::*;

  logic [1:0] miso_sync_q;
  srap_host_st_t st_q;
  logic [3:0] cnt_q;
  logic [2:0] bit_q;
  srap_byte_t sh_q;
  srap_byte_t rx_q;
  srap_byte_t rx_data_q;
  logic rx_valid_q;
  logic sclk_q;
  logic sel_q;
  logic mosi_q;
  logic wait_q;
  logic last_q;
  logic wr_seen_q;
  logic abort_q;
  logic [1:0] fill_q;
  logic at_gap;
  logic go_fill;
  logic go_end;
  logic load;
  logic cmd_now;
  srap_byte_t nxt;

  // Byte boundary decisions
  assign at_gap = (st_q == HST_LOW) & wait_q;
  assign go_fill = (fill_q != 2'h0) & ~abort_q;
  assign go_end = ~go_fill & (last_q | abort_q);
  assign tx_ready_o = (st_q == HST_IDLE) | (at_gap & ~go_fill & ~go_end);
  assign load = (tx_ready_o & tx_valid_i) | (at_gap & go_fill);
  assign nxt = (at_gap & go_fill) ? srap_cmd(1'b1, `SRAP_FILLER_ADDR) : tx_data_i;
  assign cmd_now = (st_q == HST_IDLE) | ~wr_seen_q;

  // Miso synchroniser
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      miso_sync_q <= 2'h0;
    end else begin
      miso_sync_q <= {miso_sync_q[0], link.miso};
    end
  end

  // Transaction bookkeeping: last byte, write seen, fillers, abort
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || st_q == HST_GAP) begin
      last_q <= 1'b0;
      wr_seen_q <= 1'b0;
      fill_q <= 2'h0;
      abort_q <= 1'b0;
    end else begin
      if (abort_i && st_q != HST_IDLE) begin
        abort_q <= 1'b1;
      end
      if (load && cmd_now && !srap_is_rd(nxt)) begin
        wr_seen_q <= 1'b1;
      end
      if (at_gap && go_fill) begin
        fill_q <= fill_q - 2'h1;
      end else if (load) begin
        last_q <= tx_last_i;
        if (tx_last_i && cmd_now && srap_is_rd(tx_data_i)) begin
          fill_q <= `SRAP_FILL_BYTES;
        end
      end
    end
  end

  // Link sequencer
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      st_q <= HST_IDLE;
      cnt_q <= 4'h0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      sclk_q <= 1'b0;
      sel_q <= 1'b0;
      mosi_q <= 1'b0;
      wait_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      unique case (st_q)
        HST_IDLE: begin
          if (load) begin
            sh_q <= nxt;
            sel_q <= 1'b1;
            bit_q <= 3'h0;
            wait_q <= 1'b0;
            cnt_q <= `SRAP_SETUP_CYC - 4'h1;
            st_q <= HST_SETUP;
          end
        end
        HST_SETUP: begin
          if (cnt_q == 4'h0) begin
            sclk_q <= 1'b1;
            mosi_q <= sh_q[7];
            sh_q <= {sh_q[6:0], 1'b0};
            cnt_q <= `SRAP_HALF_CYC - 4'h1;
            st_q <= HST_HIGH;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        HST_HIGH: begin
          if (cnt_q == 4'h0) begin
            sclk_q <= 1'b0;
            cnt_q <= `SRAP_HALF_CYC - 4'h1;
            st_q <= HST_LOW;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        HST_LOW: begin
          if (wait_q) begin
            if (load) begin
              // Select stays high between bytes
              sclk_q <= 1'b1;
              mosi_q <= nxt[7];
              sh_q <= {nxt[6:0], 1'b0};
              wait_q <= 1'b0;
              cnt_q <= `SRAP_HALF_CYC - 4'h1;
              st_q <= HST_HIGH;
            end else if (go_end) begin
              cnt_q <= `SRAP_HOLD_CYC - 4'h1;
              st_q <= HST_HOLD;
            end
          end else if (cnt_q == 4'h0) begin
            rx_q <= {rx_q[6:0], miso_sync_q[1]};
            if (bit_q == 3'h7) begin
              rx_data_q <= {rx_q[6:0], miso_sync_q[1]};
              rx_valid_q <= 1'b1;
              wait_q <= 1'b1;
              bit_q <= 3'h0;
            end else begin
              bit_q <= bit_q + 3'h1;
              sclk_q <= 1'b1;
              mosi_q <= sh_q[7];
              sh_q <= {sh_q[6:0], 1'b0};
              cnt_q <= `SRAP_HALF_CYC - 4'h1;
              st_q <= HST_HIGH;
            end
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        HST_HOLD: begin
          if (cnt_q == 4'h0) begin
            sel_q <= 1'b0;
            mosi_q <= 1'b0;
            cnt_q <= `SRAP_GAP_CYC - 4'h1;
            st_q <= HST_GAP;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        HST_GAP: begin
          if (cnt_q == 4'h0) begin
            st_q <= HST_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
      endcase
    end
  end

  // Outputs
  assign link.sclk = sclk_q;
  assign link.sel = sel_q;
  assign link.mosi = mosi_q;
  assign rx_valid_o = rx_valid_q;
  assign rx_data_o = rx_data_q;
  assign busy_o = (st_q != HST_IDLE);

endmodule

// ---- testbench/srap_props.sv ----
// Purpose: wire checks on the link between the two ends
// Assumes: host end makes sclk, sel and mosi from the core clock
// Notes:   half period of sclk is four core clocks
`timescale 1ns/10ps
module srap_props (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Link wires
  input wire logic sclk_i,
  input wire logic sel_i,
  input wire logic mosi_i,
  input wire logic miso_i
);
  logic sclk_q;
  logic [2:0] fall_cnt_q;
  logic [3:0] lo_cnt_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  // Previous sclk level for edge finding
  always_ff @(posedge clock_i) begin
    sclk_q <= sclk_i;
  end

  // Falling edges counted within one frame
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !sel_i) begin
      fall_cnt_q <= 3'h0;
    end else if (sclk_q && !sclk_i) begin
      fall_cnt_q <= fall_cnt_q + 3'h1;
    end
  end

  // Cycles since sclk last went low, saturating
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || sclk_i) begin
      lo_cnt_q <= 4'h0;
    end else if (lo_cnt_q != 4'hf) begin
      lo_cnt_q <= lo_cnt_q + 4'h1;
    end
  end

  chk_idle_clk_low: assert property (!sel_i |-> !sclk_i)
    else $error("sclk high while select is low");
  chk_high_phase: assert property ($rose(sclk_i) |-> sclk_i [*4] ##1 !sclk_i)
    else $error("sclk high phase not four clocks");
  chk_low_phase: assert property ($fell(sclk_i) |-> !sclk_i [*4])
    else $error("sclk low phase under four clocks");
  chk_mosi_held: assert property ((sclk_i && sclk_q) |-> $stable(mosi_i))
    else $error("mosi moved while sclk high");
  chk_sel_setup: assert property ($rose(sel_i) |-> !sclk_i ##1 sclk_i)
    else $error("sclk not one clock after select");
  chk_sel_hold: assert property ($fell(sel_i) |-> lo_cnt_q >= 4'h7)
    else $error("select dropped too soon after sclk");
  chk_sel_gap: assert property ($fell(sel_i) |-> !sel_i [*2])
    else $error("select low gap too short");
  chk_whole_bytes: assert property ($fell(sel_i) |-> fall_cnt_q == 3'h0)
    else $error("frame ended inside a byte");

  // Main traffic shapes
  cov_frame: cover property ($rose(sel_i) ##[1:1000] $fell(sel_i));
  cov_miso_high: cover property ((sel_i && miso_i) [*8]);
  cov_byte_end: cover property (sclk_q && !sclk_i && fall_cnt_q == 3'h7);
endmodule

// ---- testbench/spi_register_access_port_tb.sv ----
// Purpose: self-checking bench joining both ends of the link
// Assumes: second link and its device end driven by the bench
// Notes:   register file is a read-only array held here
`timescale 1ns/10ps
module spi_register_access_port_tb;
  import srap_pkg::*;
  logic clock_i;
  logic reset_n_i;
  logic tx_valid, tx_last, tx_ready, abort, rx_valid, busy;
  logic rd_a, wr_a, bad_en, fault_a, fault_b;
  srap_byte_t tx_data, rx_data, wdata_a;
  srap_stat_t stat_a, stat_b;
  srap_addr_t addr_a, bad_addr;
  srap_byte_t mem [128];
  srap_byte_t rxq [$];
  logic [14:0] wq [$];
  int n_rd, n_fa, n_fb, n_fail, comparisons, seed;

  srap_if link_a ();
  srap_if link_b ();

  srap_props srap_props_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .sclk_i(link_a.sclk),
    .sel_i(link_a.sel), .mosi_i(link_a.mosi), .miso_i(link_a.miso));
  srap_host srap_host_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .link(link_a.host),
    .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_last_i(tx_last), .tx_ready_o(tx_ready),
    .abort_i(abort), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .busy_o(busy));
  srap_dev srap_dev_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .link(link_a.dev),
    .status_i(stat_a), .reg_rd_o(rd_a), .reg_wr_o(wr_a), .reg_addr_o(addr_a),
    .reg_wdata_o(wdata_a), .reg_rdata_i(mem[addr_a]),
    .reg_addr_bad_i(bad_en && addr_a == bad_addr), .fault_o(fault_a));
  srap_dev srap_dev_b_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .link(link_b.dev),
    .status_i(stat_b), .reg_rd_o(), .reg_wr_o(), .reg_addr_o(), .reg_wdata_o(),
    .reg_rdata_i(8'h00), .reg_addr_bad_i(1'b0), .fault_o(fault_b));

  // Core clock
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // Watchdog against a hung handshake
  initial begin
    #(40 * 30000);
    n_fail++;
    close_out();
  end

  // Record what both ends hand out
  always @(posedge clock_i) begin
    if (wr_a === 1'b1) wq.push_back({addr_a, wdata_a});
    if (rd_a === 1'b1) n_rd++;
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (fault_a === 1'b1) n_fa++;
    if (fault_b === 1'b1) n_fb++;
  end

  // Address of the j-th byte of a burst, 7-bit wrap
  function automatic srap_addr_t next_addr(input srap_addr_t a, input int j);
    return a + 7'(j);
  endfunction

  task automatic cmp_v(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_cnt(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // One host transaction; without last it is aborted after the bytes
  task automatic send(input srap_byte_t q [$], input bit last);
    int k;
    rxq.delete();
    wq.delete();
    n_rd = 0;
    n_fa = 0;
    foreach (q[i]) begin
      tx_valid = 1'b1;
      tx_data = q[i];
      tx_last = last && (i == q.size() - 1);
      k = 0;
      while (tx_ready !== 1'b1 && k < 2000) begin
        @(negedge clock_i);
        k++;
      end
      cmp_cnt("tx_ready in time", 1, int'(k < 2000));
      @(negedge clock_i);
    end
    tx_valid = 1'b0;
    tx_last = 1'b0;
    k = 0;
    while (!last && rxq.size() < q.size() && k < 2000) begin
      @(negedge clock_i);
      k++;
    end
    cmp_cnt("rx bytes in time", 1, int'(k < 2000));
    abort = !last;
    @(negedge clock_i);
    abort = 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 4000) begin
      @(negedge clock_i);
      k++;
    end
    cmp_cnt("busy ends in time", 1, int'(k < 4000));
    repeat (8) @(negedge clock_i);
  endtask

  // Bench-made frame on the second link, n clock pulses
  task automatic b_frame(input logic [31:0] bits, input int n, input int fault_exp);
    srap_byte_t got;
    stat_b = 16'($random(seed));
    n_fb = 0;
    link_b.sel = 1'b1;
    repeat (2) @(negedge clock_i);
    for (int i = 0; i < n; i++) begin
      link_b.sclk = 1'b1;
      link_b.mosi = bits[31 - i];
      repeat (4) @(negedge clock_i);
      link_b.sclk = 1'b0;
      repeat (4) @(negedge clock_i);
      if (i < 8) got[7 - i] = link_b.miso;
    end
    repeat (7) @(negedge clock_i);
    link_b.sel = 1'b0;
    link_b.mosi = ~link_b.mosi;
    repeat (8) @(negedge clock_i);
    cmp_v("first byte b", {8'h00, stat_b[15:8]}, {8'h00, got});
    cmp_v("miso after frame", 16'(fault_exp), {15'h0000, link_b.miso});
    cmp_cnt("fault pulses b", fault_exp, n_fb);
    $display("test link b frame of %0d pulses done", n);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    srap_byte_t q [$];
    srap_addr_t a;
    srap_addr_t x;
    int n;
    {reset_n_i, tx_valid, tx_last, abort, bad_en} = 5'b00000;
    {link_b.sclk, link_b.sel, link_b.mosi} = 3'b000;
    tx_data = 8'h00;
    bad_addr = 7'h2c;
    seed = 32'h7a59;
    stat_a = 16'h0000;
    stat_b = 16'h0000;
    foreach (mem[i]) mem[i] = 8'($random(seed));
    repeat (16) @(negedge clock_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    // Write to a refused address, host aborts
    stat_a = 16'($random(seed));
    bad_en = 1'b1;
    send('{8'h2c, 8'h11, 8'h22}, 1'b0);
    cmp_cnt("writes after fault", 0, wq.size());
    cmp_cnt("fault pulses", 1, n_fa);
    cmp_v("miso after fault", 16'h00ff, {8'h00, rxq[2]});
    bad_en = 1'b0;
    $display("test address fault done");
    // Filler then boundary reads
    stat_a = 16'($random(seed));
    send('{8'hbf, 8'h80, 8'hff}, 1'b1);
    cmp_cnt("rx bytes", 5, rxq.size());
    cmp_v("status", stat_a, {rxq[0], rxq[1]});
    cmp_v("filler data", 16'h0000, {8'h00, rxq[2]});
    cmp_v("read low end", {8'h00, mem[0]}, {8'h00, rxq[3]});
    cmp_v("read high end", {8'h00, mem[127]}, {8'h00, rxq[4]});
    cmp_cnt("reads", 2, n_rd);
    $display("test reads done");
    // Combined read then write
    a = 7'($random(seed));
    x = 7'($random(seed));
    if (a == 7'h3f) a = 7'h3e;
    stat_a = 16'($random(seed));
    q = '{{1'b1, a}, {1'b0, x}, 8'($random(seed))};
    send(q, 1'b1);
    cmp_cnt("combined rx bytes", 3, rxq.size());
    cmp_v("status once", stat_a, {rxq[0], rxq[1]});
    cmp_v("combined read", {8'h00, mem[a]}, {8'h00, rxq[2]});
    cmp_cnt("combined writes", 1, wq.size());
    cmp_v("combined write", {1'b0, x, q[2]}, {1'b0, wq[0]});
    $display("test combined done");
    // Bursts, first one wrapping past the top address
    for (int t = 0; t < 5; t++) begin
      a = (t == 0) ? 7'h7e : 7'($random(seed));
      n = (t == 0) ? 4 : 1 + int'($unsigned($random(seed)) % 4);
      stat_a = 16'($random(seed));
      q = '{{1'b0, a}};
      repeat (n) q.push_back(8'($random(seed)));
      send(q, 1'b1);
      cmp_v("burst status", stat_a, {rxq[0], rxq[1]});
      cmp_cnt("burst writes", n, wq.size());
      foreach (wq[j]) cmp_v("burst word", {1'b0, next_addr(a, j), q[j + 1]}, {1'b0, wq[j]});
      $display("test burst %0d done", t);
    end
    // Clean frames and framing faults on the second link
    b_frame(32'hbfbf_bf00, 24, 0);
    b_frame(32'hbfbf_0000, 12, 1);
    b_frame(32'h0500_0000, 8, 1);
    b_frame(32'hbfbf_bf00, 24, 0);
    close_out();
  end
endmodule
